// *** verilog/emra_pkg.sv ***
`default_nettype none
package emra_pkg;

    // Special-function-register map of the measurement bridge.
    localparam logic [7:0] SFR_PTR_ADDR   = 8'h91;
    localparam logic [7:0] SFR_DATA_LOW   = 8'h92;
    localparam logic [7:0] SFR_DATA_MID   = 8'h93;
    localparam logic [7:0] SFR_DATA_HIGH  = 8'h94;
    localparam logic [7:0] SFR_IRQ_EN_L   = 8'hd9;
    localparam logic [7:0] SFR_IRQ_ST_L   = 8'hdc;

    // Low-byte addresses of the three-byte latched values.
    localparam int         MEAS_CHANNELS  = 4;
    localparam logic [7:0] MEAS_BASE [MEAS_CHANNELS] =
        '{8'hd1, 8'hd4, 8'he2, 8'he5};

    // Pointer layout.
    localparam int         PTR_DIR_BIT    = 7;
    localparam int         PTR_ADDR_W     = 7;

    // Reset values.
    localparam logic [7:0]  PTR_RESET     = 8'h00;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [23:0] WORD_RESET    = 24'h000000;

    // Clock rates and the derived core tick spacing.
    localparam int CLK_HZ       = 125_000_000;
    localparam int CORE_HZ      = 819_200;
    localparam int CORE_DIV_CYC = CLK_HZ / CORE_HZ;

    // Internal registers that are only one byte long.
    function automatic logic reg_is_byte(input logic [PTR_ADDR_W-1:0] a);
        case (a)
            7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h13: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    typedef enum logic [1:0] {
        EMRA_IDLE = 2'b00,
        EMRA_WAIT = 2'b01,
        EMRA_DONE = 2'b10
    } emra_state_t;

endpackage
`default_nettype wire

// *** verilog/emra_xfer_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface emra_xfer_if;
    logic        start;
    logic        write;
    logic [6:0]  addr;
    logic [23:0] wdata;
    logic        busy;
    logic        done;
    logic [23:0] rdata;

    modport ctl (output start, output write, output addr, output wdata,
                 input busy, input done, input rdata);
    modport eng (input start, input write, input addr, input wdata,
                 output busy, output done, output rdata);
endinterface
`default_nettype wire

// *** verilog/emra_xfer.sv ***
`timescale 1ns/1ns
`default_nettype none
module emra_xfer
    import emra_pkg::*;
#(
    parameter int CORE_DIV = CORE_DIV_CYC
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    emra_xfer_if.eng         xfer,
    output logic             core_req_o,
    output logic             core_write_o,
    output logic [6:0]       core_addr_o,
    output logic [23:0]      core_wdata_o,
    output logic             core_byte_o,
    input  wire logic [23:0] core_rdata_i
);

    localparam int DW = $clog2(CORE_DIV);

    if (CORE_DIV < 2) begin : g_chk
        $error("CORE_DIV must be at least 2");
    end

    logic [DW-1:0] div_r;
    logic          tick;
    emra_state_t   state_r;
    logic [23:0]   rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // The core runs on a slower tick; every access is taken on a tick edge.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_r <= '0;
        end else if (div_r == DW'(CORE_DIV - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + DW'(1);
        end
    end
    assign tick = (div_r == DW'(CORE_DIV - 1));

    ////////////////////////////////////////////////////////////////////////
    // Request is held from start and issued on the next tick, so latency is
    // bounded by one core period plus one cycle.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r      <= EMRA_IDLE;
            core_req_o   <= 1'b0;
            core_write_o <= 1'b0;
            core_addr_o  <= 7'h00;
            core_wdata_o <= WORD_RESET;
            core_byte_o  <= 1'b0;
            rdata_r      <= WORD_RESET;
        end else begin
            core_req_o <= 1'b0;
            case (state_r)
                EMRA_IDLE: begin
                    if (xfer.start) begin
                        state_r      <= EMRA_WAIT;
                        core_write_o <= xfer.write;
                        core_addr_o  <= xfer.addr;
                        core_byte_o  <= reg_is_byte(xfer.addr);
                        // One-byte targets get only the low data byte.
                        core_wdata_o <= reg_is_byte(xfer.addr) ?
                            {16'h0000, xfer.wdata[7:0]} : xfer.wdata;
                    end
                end
                EMRA_WAIT: begin
                    if (tick) begin
                        core_req_o <= 1'b1;
                        state_r    <= EMRA_DONE;
                        // Upper bytes of a one-byte read return as zero.
                        rdata_r    <= core_byte_o ?
                            {16'h0000, core_rdata_i[7:0]} : core_rdata_i;
                    end
                end
                EMRA_DONE: begin
                    state_r <= EMRA_IDLE;
                end
                default: begin
                    state_r <= EMRA_IDLE;
                end
            endcase
        end
    end

    assign xfer.busy  = (state_r != EMRA_IDLE);
    assign xfer.done  = (state_r == EMRA_DONE);
    assign xfer.rdata = rdata_r;

endmodule // emra_xfer
`default_nettype wire

// *** verilog/emra_bridge.sv ***
`timescale 1ns/1ns
`default_nettype none
module emra_bridge
    import emra_pkg::*;
#(
    parameter int CORE_DIV = CORE_DIV_CYC
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Special-function-register bus of the processor core.
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic [7:0]       sfr_rdata_o,
    // Live values from the measurement core.
    input  wire logic [23:0] vrms_i,
    input  wire logic [23:0] irms_i,
    input  wire logic [23:0] wave_one_i,
    input  wire logic [23:0] wave_two_i,
    input  wire logic [23:0] irq_status_i,
    output logic [23:0]      irq_enable_o,
    output logic [23:0]      irq_status_clr_o,
    // Internal register port of the measurement core.
    output logic             core_req_o,
    output logic             core_write_o,
    output logic [6:0]       core_addr_o,
    output logic [23:0]      core_wdata_o,
    output logic             core_byte_o,
    input  wire logic [23:0] core_rdata_i,
    output logic             xfer_busy_o
);

    emra_xfer_if xfer ();

    // The transfer engine cannot count a divider shorter than two cycles.
    if (CORE_DIV < 2) begin : g_chk
        $error("CORE_DIV must be at least 2");
    end

    logic [7:0]  measurement_pointer_address_r;
    logic [7:0]  pointer_data_low_r;
    logic [7:0]  pointer_data_middle_r;
    logic [7:0]  pointer_data_high_r;
    logic [23:0] irq_enable_r;
    logic [23:0] irq_clr_r;
    logic [7:0]  rdata_r;
    logic [7:0]  rd_nxt;
    logic        ptr_wr;
    logic [23:0] meas_live [MEAS_CHANNELS];
    logic [23:0] meas_latch_r [MEAS_CHANNELS];
    logic [2:0]  meas_hit [MEAS_CHANNELS];

    assign meas_live[0] = vrms_i;
    assign meas_live[1] = irms_i;
    assign meas_live[2] = wave_one_i;
    assign meas_live[3] = wave_two_i;

    ////////////////////////////////////////////////////////////////////////
    // Pointer write starts a transfer. A write while one is still running is
    // dropped whole, so the running transfer keeps its address and data.
    // Nothing flags the dropped write; software has to wait out the busy
    // time, which is the price of keeping the engine a single request deep.
    assign ptr_wr = sfr_wr_i && (sfr_addr_i == SFR_PTR_ADDR)
                    && !xfer.busy;

    assign xfer.start = ptr_wr;
    assign xfer.write = sfr_wdata_i[PTR_DIR_BIT];
    assign xfer.addr  = sfr_wdata_i[PTR_ADDR_W-1:0];
    assign xfer.wdata = {pointer_data_high_r, pointer_data_middle_r,
                         pointer_data_low_r};

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            measurement_pointer_address_r <= PTR_RESET;
        end else if (ptr_wr) begin
            measurement_pointer_address_r <= sfr_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data SFRs. A finished read overrides a software write in the same
    // cycle; otherwise they hold until software or a later read changes them.
    // Losing the software write there is deliberate: the read was asked first.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pointer_data_low_r    <= BYTE_RESET;
            pointer_data_middle_r <= BYTE_RESET;
            pointer_data_high_r   <= BYTE_RESET;
        end else if (xfer.done && !core_write_o) begin
            pointer_data_low_r    <= xfer.rdata[7:0];
            pointer_data_middle_r <= xfer.rdata[15:8];
            pointer_data_high_r   <= xfer.rdata[23:16];
        end else if (sfr_wr_i) begin
            if (sfr_addr_i == SFR_DATA_LOW) begin
                pointer_data_low_r <= sfr_wdata_i;
            end
            if (sfr_addr_i == SFR_DATA_MID) begin
                pointer_data_middle_r <= sfr_wdata_i;
            end
            if (sfr_addr_i == SFR_DATA_HIGH) begin
                pointer_data_high_r <= sfr_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enable bytes are held here; writing a status byte sends a
    // one-cycle clear pulse for each bit written as one.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_enable_r <= WORD_RESET;
            irq_clr_r    <= WORD_RESET;
        end else begin
            irq_clr_r <= WORD_RESET;
            if (sfr_wr_i) begin
                for (int b = 0; b < 3; b++) begin
                    if (sfr_addr_i == SFR_IRQ_EN_L + 8'(b)) begin
                        irq_enable_r[8*b +: 8] <= sfr_wdata_i;
                    end
                    if (sfr_addr_i == SFR_IRQ_ST_L + 8'(b)) begin
                        irq_clr_r[8*b +: 8] <= sfr_wdata_i;
                    end
                end
            end
        end
    end

    assign irq_enable_o     = irq_enable_r;
    assign irq_status_clr_o = irq_clr_r;

    ////////////////////////////////////////////////////////////////////////
    // Three-byte values: the high-byte read captures all 24 bits at once, so
    // the later low and middle reads belong to the same sample.
    for (genvar g = 0; g < MEAS_CHANNELS; g++) begin : g_meas
        for (genvar k = 0; k < 3; k++) begin : g_byte
            assign meas_hit[g][k] = (sfr_addr_i == MEAS_BASE[g] + 8'(k));
        end
        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                meas_latch_r[g] <= WORD_RESET;
            end else if (sfr_rd_i && meas_hit[g][2]) begin
                meas_latch_r[g] <= meas_live[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer. Unmapped addresses read as zero.
    always_comb begin
        rd_nxt = BYTE_RESET;
        case (sfr_addr_i)
            SFR_PTR_ADDR:  rd_nxt = measurement_pointer_address_r;
            SFR_DATA_LOW:  rd_nxt = pointer_data_low_r;
            SFR_DATA_MID:  rd_nxt = pointer_data_middle_r;
            SFR_DATA_HIGH: rd_nxt = pointer_data_high_r;
            default:       rd_nxt = BYTE_RESET;
        endcase
        for (int b = 0; b < 3; b++) begin
            if (sfr_addr_i == SFR_IRQ_EN_L + 8'(b)) begin
                rd_nxt = irq_enable_r[8*b +: 8];
            end
            // Each status byte is captured alone at its own read.
            if (sfr_addr_i == SFR_IRQ_ST_L + 8'(b)) begin
                rd_nxt = irq_status_i[8*b +: 8];
            end
        end
        for (int c = 0; c < MEAS_CHANNELS; c++) begin
            if (meas_hit[c][2]) begin
                rd_nxt = meas_live[c][23:16];
            end
            if (meas_hit[c][1]) begin
                rd_nxt = meas_latch_r[c][15:8];
            end
            if (meas_hit[c][0]) begin
                rd_nxt = meas_latch_r[c][7:0];
            end
        end
    end

    // Read data is registered; it appears the cycle after the read strobe
    // and holds until the next read.
    // Registering costs a cycle of latency but keeps the wide multiplexer
    // out of the processor's data path.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= BYTE_RESET;
        end else if (sfr_rd_i) begin
            rdata_r <= rd_nxt;
        end
    end

    assign sfr_rdata_o = rdata_r;
    assign xfer_busy_o = xfer.busy;

    ////////////////////////////////////////////////////////////////////////
    // Transfer engine on the slower core tick.
    emra_xfer #(
        .CORE_DIV (CORE_DIV)
    ) u_xfer (
        .clock_i      (clock_i),
        .rst_n_i      (rst_n_i),
        .xfer         (xfer.eng),
        .core_req_o   (core_req_o),
        .core_write_o (core_write_o),
        .core_addr_o  (core_addr_o),
        .core_wdata_o (core_wdata_o),
        .core_byte_o  (core_byte_o),
        .core_rdata_i (core_rdata_i)
    );

endmodule // emra_bridge
`default_nettype wire

// *** bench/emra_bridge_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module emra_bridge_properties #(
    parameter int CORE_DIV = 152
) (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  sfr_addr_i,
    input wire logic        sfr_wr_i,
    input wire logic        sfr_rd_i,
    input wire logic [7:0]  sfr_wdata_i,
    input wire logic [7:0]  sfr_rdata_o,
    input wire logic [23:0] vrms_i,
    input wire logic [23:0] irq_status_i,
    input wire logic        core_req_o,
    input wire logic        core_write_o,
    input wire logic [6:0]  core_addr_o,
    input wire logic [23:0] core_wdata_o,
    input wire logic        core_byte_o,
    input wire logic        xfer_busy_o
);
    localparam int REQ_MAX = CORE_DIV + 1;
    wire logic ptr_wr = sfr_wr_i && sfr_addr_i == 8'h91;
    wire logic start  = ptr_wr && !xfer_busy_o;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_start; start |=> xfer_busy_o; endproperty
    a_start: assert property (p_start) else $error("busy did not rise");
    property p_busy_wr; ptr_wr && xfer_busy_o |=> $stable(core_addr_o); endproperty
    a_busy_wr: assert property (p_busy_wr) else $error("busy write taken");
    property p_decode; start |=> core_write_o == $past(sfr_wdata_i[7])
        && core_addr_o == $past(sfr_wdata_i[6:0]); endproperty
    a_decode: assert property (p_decode) else $error("pointer decode");
    property p_req; $rose(xfer_busy_o) |-> ##[1:REQ_MAX] core_req_o; endproperty
    a_req: assert property (p_req) else $error("request late");
    property p_done; core_req_o |-> xfer_busy_o ##1 !xfer_busy_o; endproperty
    a_done: assert property (p_done) else $error("busy end wrong");
    property p_byte; core_req_o && core_write_o && core_byte_o
        |-> core_wdata_o[23:8] == 16'h0000; endproperty
    a_byte: assert property (p_byte) else $error("byte write upper");
    property p_rms; sfr_rd_i && sfr_addr_i == 8'hd3
        |=> sfr_rdata_o == $past(vrms_i[23:16]); endproperty
    a_rms: assert property (p_rms) else $error("high byte read");
    property p_irq; sfr_rd_i && sfr_addr_i == 8'hdc
        |=> sfr_rdata_o == $past(irq_status_i[7:0]); endproperty
    a_irq: assert property (p_irq) else $error("irq byte read");
endmodule // emra_bridge_properties

bind emra_bridge emra_bridge_properties #(.CORE_DIV(CORE_DIV)) props_inst (
    .clock_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .vrms_i, .irq_status_i, .core_req_o, .core_write_o,
    .core_addr_o, .core_wdata_o, .core_byte_o, .xfer_busy_o
);
`default_nettype wire

// *** bench/emra_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module emra_core_model (
    input  wire logic        clock_i,
    input  wire logic        core_req_i,
    input  wire logic        core_write_i,
    input  wire logic [6:0]  core_addr_i,
    input  wire logic [23:0] core_wdata_i,
    output logic [23:0]      core_rdata_o
);
    // Plain always, not always_ff: the bench preloads this page directly.
    logic [23:0] mem [128];

    // Combinational read, because the bridge samples on the request edge.
    assign core_rdata_o = mem[core_addr_i];

    always @(posedge clock_i) begin
        if (core_req_i && core_write_i) begin
            mem[core_addr_i] <= core_wdata_i;
        end
    end
endmodule // emra_core_model
`default_nettype wire

// *** bench/energy_meter_register_access_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module energy_meter_register_access_bench;
    import emra_pkg::*;
    localparam int DIV = 4;
    logic        clock_i;
    logic        rst_n_i;
    logic        sfr_wr_i;
    logic        sfr_rd_i;
    logic [7:0]  sfr_addr_i;
    logic [7:0]  sfr_wdata_i;
    logic [7:0]  sfr_rdata_o;
    logic [23:0] rdata;
    logic [23:0] irq_enable_o;
    logic [23:0] irq_status_clr_o;
    logic [23:0] live [4];
    logic [23:0] irq_status_i;
    logic [23:0] core_rdata_i;
    logic [23:0] core_wdata_o;
    logic [23:0] exp;
    logic [6:0]  core_addr_o;
    logic        core_req_o;
    logic        core_write_o;
    logic        core_byte_o;
    logic        xfer_busy_o;
    logic [7:0]  rs [6] = '{8'h91, 8'h92, 8'h93, 8'h94, 8'hd1, 8'h00};
    logic [7:0]  ra [3] = '{8'h16, 8'h0c, 8'h13};
    int          fail_count;
    int          num_checks;
    int          cycles;
    int          cap [4];
    int          w;

    emra_bridge #(.CORE_DIV(DIV)) emra_bridge_inst (
        .clock_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
        .sfr_rdata_o, .vrms_i(live[0]), .irms_i(live[1]),
        .wave_one_i(live[2]), .wave_two_i(live[3]), .irq_status_i,
        .irq_enable_o, .irq_status_clr_o, .core_req_o, .core_write_o,
        .core_addr_o, .core_wdata_o, .core_byte_o, .core_rdata_i, .xfer_busy_o
    );
    emra_core_model emra_core_model_inst (
        .clock_i, .core_req_i(core_req_o), .core_write_i(core_write_o),
        .core_addr_i(core_addr_o), .core_wdata_i(core_wdata_o),
        .core_rdata_o(core_rdata_i)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] want);
        num_checks++;
        if (got !== want) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Strobes drop for an idle cycle so no task re-raises them in one step.
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge clock_i) sfr_wr_i = 1'b0;
        @(negedge clock_i);
    endtask

    task automatic sfr_r(input logic [7:0] a);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge clock_i) sfr_rd_i = 1'b0;
        rdata = {16'h0, sfr_rdata_o};
        @(negedge clock_i);
    endtask

    // Pointer write, bounded wait on busy, then the software countdown.
    task automatic ptr(input logic [7:0] p);
        sfr_w(8'h91, p);
        for (int k = 0; k < 40 && xfer_busy_o !== 1'b0; k++) @(negedge clock_i);
        chk({23'h0, xfer_busy_o}, 24'h0);
        repeat (5) @(negedge clock_i);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test;
        end
    end

    initial begin
        rst_n_i = 1'b0;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        irq_status_i = 24'h0;
        foreach (live[c]) live[c] = 24'h0;
        w = $urandom(32'h6d90524a);
        for (int a = 0; a < 128; a++) begin
            emra_core_model_inst.mem[a] = 24'($urandom);
        end
        repeat (12) @(negedge clock_i);
        rst_n_i = 1'b1;
        @(negedge clock_i);
        foreach (rs[i]) begin
            sfr_r(rs[i]);
            chk(rdata, 24'h0);
        end
        // Low byte first must still show the older capture.
        for (int c = 0; c < 4; c++) begin
            live[c] = 24'($urandom);
            sfr_r(MEAS_BASE[c]);
            chk(rdata, 24'(cap[c] & 8'hff));
            sfr_r(MEAS_BASE[c] + 8'h02);
            chk(rdata, 24'(live[c][23:16]));
            cap[c] = int'(live[c]);
            live[c] = ~live[c];
            sfr_r(MEAS_BASE[c] + 8'h01);
            chk(rdata, 24'((cap[c] >> 8) & 8'hff));
            sfr_r(MEAS_BASE[c]);
            chk(rdata, 24'(cap[c] & 8'hff));
        end
        for (int b = 0; b < 3; b++) begin
            irq_status_i = 24'($urandom);
            sfr_r(SFR_IRQ_ST_L + 8'(b));
            chk(rdata, 24'(irq_status_i[b*8 +: 8]));
            sfr_w(SFR_IRQ_EN_L + 8'(b), 8'h5a ^ 8'(b));
            sfr_r(SFR_IRQ_EN_L + 8'(b));
            chk(rdata, 24'(8'h5a ^ 8'(b)));
            // A status write clears for exactly one cycle.
            sfr_addr_i = SFR_IRQ_ST_L + 8'(b);
            sfr_wdata_i = 8'hc3 ^ 8'(b);
            sfr_wr_i = 1'b1;
            @(negedge clock_i) sfr_wr_i = 1'b0;
            chk(irq_status_clr_o, 24'(8'hc3 ^ 8'(b)) << (8 * b));
            @(negedge clock_i);
            chk(irq_status_clr_o, 24'h0);
        end
        chk(irq_enable_o, 24'h585b5a);
        sfr_w(8'h93, 8'h01);
        sfr_w(8'h92, 8'h55);
        ptr(8'h94);
        chk(emra_core_model_inst.mem[7'h14], 24'h000155);
        w = $urandom;
        sfr_w(8'h94, 8'hff);
        sfr_w(8'h93, 8'hff);
        sfr_w(8'h92, w[7:0]);
        ptr(8'h8b);
        chk(emra_core_model_inst.mem[7'h0b], {16'h0, w[7:0]});
        // A second pointer write while busy has to be dropped.
        exp = emra_core_model_inst.mem[7'h16];
        sfr_w(8'h91, 8'h95);
        ptr(8'h96);
        chk(emra_core_model_inst.mem[7'h15], {16'hffff, w[7:0]});
        chk(emra_core_model_inst.mem[7'h16], exp);
        foreach (ra[i]) begin
            ptr(ra[i]);
            exp = emra_core_model_inst.mem[ra[i][6:0]];
            if (ra[i] != 8'h16) exp[23:8] = 16'h0;
            for (int b = 0; b < 3; b++) begin
                sfr_r(8'h92 + 8'(b));
                chk(rdata, 24'(exp[b*8 +: 8]));
            end
        end
        end_of_test;
    end
endmodule // energy_meter_register_access_bench
`default_nettype wire
